//--- gbf_pkg.sv
// Constants and carrier types shared by the GCM block formatter.
// Functional notes
// (RQ1) AES-128: every emitted block is 16 octets.
// (RQ2) Integrity code 8 octets, length field 2.
// (RQ3) Nonce: source, destination, key id, sequence.
// (RQ4) Nonce components placed most-significant octet first.
// (RQ5) B_0: flags 0x59, nonce, message length.
// (RQ6) B_0 length MS-first, nonce LS-first.
// (RQ7) B_1: length 14+offset, header, offset, reserved, zero.
// (RQ8) B_1 length MS-first, fields in transmission order.
// (RQ9) Clear payload blocks, then encrypted payload blocks.
// (RQ10) Last block of each portion zero padded.
// (RQ11) Padding octets never go onto the medium.
// (RQ12) Payload octets ordered earliest leftmost.
// (RQ13) Counter block: flags 0x01, nonce, counter.
// (RQ14) Counter cleared per frame, then increments.
// (RQ15) Counter MS-first, nonce LS-first in counter blocks.
// (RQ16) Never reuse a nonce under one key.
// (RQ17) Encrypt only payload beyond offset; authenticate all.
// (RQ18) 48-bit frame counter, incremented before each frame.
// (RQ19) Blocks in order, advance only when accepted.
// (RQ20) Flag last block of each payload portion.
package gbf_pkg;

  // ****************************************************************
  // Widths and fixed values
  // ****************************************************************
  localparam int BLK_BITS     = 128;
  localparam int BLK_OCTETS   = 16;
  localparam int MIC_OCTETS   = 8;
  localparam int LEN_OCTETS   = 2;
  localparam int NONCE_OCTETS = 13;
  localparam int NONCE_BITS   = 8 * NONCE_OCTETS;
  localparam int SEQ_BITS     = 48;
  localparam int FIFO_DEPTH   = 4;

  localparam logic [7:0]          B0_FLAGS   = 8'h59;
  localparam logic [7:0]          CTR_FLAGS  = 8'h01;
  localparam logic [7:0]          ZERO_OCTET = 8'h00;
  localparam logic [15:0]         AAD_BASE   = 16'h000e;
  localparam logic [15:0]         CTR_RESET  = 16'h0000;
  localparam logic [SEQ_BITS-1:0] SEQ_RESET  = 48'h000000000000;
  localparam logic [SEQ_BITS-1:0] SEQ_MAX    = 48'hffffffffffff;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef enum logic [1:0] {
    KIND_AUTH  = 2'h0,
    KIND_CLEAR = 2'h1,
    KIND_ENC   = 2'h2,
    KIND_CTR   = 2'h3
  } gbf_kind_t;

  typedef struct packed {
    logic [15:0] source_address;
    logic [15:0] destination_address;
    logic [23:0] temporal_key_id;
    logic [79:0] mac_header;
    logic [15:0] encryption_offset;
    logic [7:0]  security_reserved;
    logic [15:0] payload_length;
  } gbf_frame_t;

  typedef struct packed {
    logic [BLK_BITS-1:0] data;
    gbf_kind_t           kind;
    logic                last_clear;
    logic                last_enc;
  } gbf_block_t;

endpackage

//--- gbf_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module gbf_fifo
  import gbf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } gbf_fifo_t;

  gbf_fifo_t st;
  gbf_fifo_t next_st;
  logic      full;
  logic      empty;

  assign empty     = (st.wr == st.rd);
  assign full      = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st.mem[st.rd[AW-1:0]];

  always_comb
  begin
    next_st = st;
    if (in_valid && !full)
    begin
      next_st.mem[st.wr[AW-1:0]] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (out_ready && !empty)
    begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

//--- gbf_frame_counter.sv
// Transmit frame counter kept for the installed temporal key.
`timescale 1ns/100ps
`default_nettype none
module gbf_frame_counter
  import gbf_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Control
  input  wire logic                key_install,
  input  wire logic                advance,
  // Status
  output logic [SEQ_BITS-1:0]      count_next,
  output logic                     exhausted
);

  typedef struct packed {
    logic [SEQ_BITS-1:0] count;
  } gbf_cnt_t;

  gbf_cnt_t st;
  gbf_cnt_t next_st;

  // The value a frame takes is the count after its increment.
  assign count_next = st.count + 48'h000000000001;
  // Once the top value is used, no frame may go out until a new key.
  assign exhausted  = (st.count == SEQ_MAX); // [RQ16]

  always_comb
  begin
    next_st = st;
    if (key_install)
    begin
      next_st.count = SEQ_RESET; // [RQ18]
    end
    else if (advance && !exhausted)
    begin
      next_st.count = count_next; // [RQ18]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st.count <= SEQ_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

//--- gbf_formatter.sv
// GCM input block formatter: nonce, B_0, B_1, payload and counter blocks.
`timescale 1ns/100ps
`default_nettype none
module gbf_formatter
  import gbf_pkg::*;
(
  // Clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                RST,
  // Key management
  input  wire logic                KEY_INSTALL,
  output logic                     KEY_EXHAUSTED,
  // Frame description from the framing logic
  input  wire logic                FRM_VALID,
  input  wire gbf_frame_t          FRM_INFO,
  output logic                     FRM_READY,
  output logic [SEQ_BITS-1:0]      FRAME_SEQUENCE_NUMBER,
  // Payload octet stream
  input  wire logic                PL_VALID,
  input  wire logic [7:0]          PL_DATA,
  output logic                     PL_READY,
  // Blocks to the cipher core
  output logic                     BLK_VALID,
  output gbf_block_t               BLK_OUT,
  input  wire logic                BLK_READY
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_B0   = 3'b001,
    ST_B1   = 3'b011,
    ST_CLR  = 3'b010,
    ST_ENC  = 3'b110,
    ST_CTR  = 3'b111
  } gbf_state_t;

  typedef struct packed {
    gbf_state_t            state;
    gbf_frame_t            frm;
    logic [NONCE_BITS-1:0] nonce;
    logic [15:0]           enc_len;
    logic [15:0]           rem;
    logic [4:0]            fill;
    logic [BLK_BITS-1:0]   acc;
    logic [15:0]           ctr;
    logic [15:0]           nctr;
  } gbf_fmt_t;

  gbf_fmt_t            st;
  gbf_fmt_t            next_st;
  gbf_block_t          blk;
  logic                push;
  logic                fifo_ready;
  logic                frame_start;
  logic                take;
  logic                emit;
  logic [SEQ_BITS-1:0] seq_next;
  logic                exhausted;

  // ****************************************************************
  // Octet order of the nonce inside B_0 and the counter blocks
  // ****************************************************************
  // The nonce is held most-significant octet first; the cipher blocks
  // want it least-significant octet first, so the octets are reversed.
  function automatic logic [NONCE_BITS-1:0] nonce_swap(input logic [NONCE_BITS-1:0] n);
    logic [NONCE_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < NONCE_OCTETS; i++)
    begin
      r[8*i +: 8] = n[8*(NONCE_OCTETS-1-i) +: 8]; // [RQ6] [RQ15]
    end
    return r;
  endfunction

  // ****************************************************************
  // Frame counter and output buffer
  // ****************************************************************
  gbf_frame_counter u_counter (
    .clk         (SYS_CLK),
    .rst         (RST),
    .key_install (KEY_INSTALL),
    .advance     (frame_start),
    .count_next  (seq_next),
    .exhausted   (exhausted)
  );

  // The buffer decouples the formatter from a cipher core that may
  // stall; when it fills, the state machine simply holds its block.
  gbf_fifo #(
    .WIDTH ($bits(gbf_block_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RST),
    .in_valid  (push),
    .in_data   (blk),
    .in_ready  (fifo_ready),
    .out_valid (BLK_VALID),
    .out_data  (BLK_OUT),
    .out_ready (BLK_READY)
  );

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  assign KEY_EXHAUSTED         = exhausted;
  assign FRM_READY             = (st.state == ST_IDLE) && !exhausted; // [RQ16]
  assign frame_start           = FRM_VALID && FRM_READY;
  assign FRAME_SEQUENCE_NUMBER = st.nonce[SEQ_BITS-1:0];
  assign take     = ((st.state == ST_CLR) || (st.state == ST_ENC))
                    && (st.fill != 5'h10) && (st.rem != 16'h0000);
  assign PL_READY = take;
  assign emit     = ((st.state == ST_CLR) || (st.state == ST_ENC))
                    && ((st.fill == 5'h10) || ((st.rem == 16'h0000) && (st.fill != 5'h00)));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    logic [16:0] blocks;
    int          idx;
    logic [15:0] clr_len;
    blocks  = '0;
    idx     = 0;
    // An offset past the payload end must not make the payload port ask
    // for octets that do not exist, so the clear portion is capped.
    clr_len = (st.frm.encryption_offset < st.frm.payload_length)
              ? st.frm.encryption_offset : st.frm.payload_length; // [RQ9]
    next_st = st;
    push    = 1'b0;
    blk     = '0;
    case (st.state)
      ST_IDLE:
      begin
        if (frame_start)
        begin
          next_st.frm   = FRM_INFO;
          // Nonce in its natural order, each field MS octet first.
          next_st.nonce = {FRM_INFO.source_address,
                           FRM_INFO.destination_address,
                           FRM_INFO.temporal_key_id,
                           seq_next}; // [RQ3] [RQ4] [RQ18]
          if (FRM_INFO.payload_length > FRM_INFO.encryption_offset)
          begin
            next_st.enc_len = FRM_INFO.payload_length - FRM_INFO.encryption_offset;
          end
          else
          begin
            next_st.enc_len = 16'h0000;
          end
          // One counter block for the integrity code plus one per
          // encrypted payload block.
          blocks       = {1'b0, next_st.enc_len} + 17'h0000f;
          next_st.nctr = blocks[16:1] >> 3;
          next_st.ctr  = CTR_RESET; // [RQ14]
          next_st.fill = 5'h00;
          next_st.acc  = '0;
          next_st.rem  = 16'h0000;
          next_st.state = ST_B0;
        end
      end
      ST_B0:
      begin
        // Length field is the encrypted length, MS octet first.
        blk.data = {B0_FLAGS, nonce_swap(st.nonce), st.enc_len}; // [RQ5] [RQ6] [RQ2]
        blk.kind = KIND_AUTH;
        push     = 1'b1;
        if (fifo_ready)
        begin
          next_st.state = ST_B1; // [RQ19]
        end
      end
      ST_B1:
      begin
        blk.data = {AAD_BASE + st.frm.encryption_offset,
                    st.frm.mac_header,
                    st.frm.encryption_offset,
                    st.frm.security_reserved,
                    ZERO_OCTET}; // [RQ7] [RQ8] [RQ17]
        blk.kind = KIND_AUTH;
        push     = 1'b1;
        if (fifo_ready)
        begin
          if (clr_len != 16'h0000)
          begin
            next_st.rem   = clr_len;
            next_st.state = ST_CLR; // [RQ9]
          end
          else if (st.enc_len != 16'h0000)
          begin
            next_st.rem   = st.enc_len;
            next_st.state = ST_ENC;
          end
          else
          begin
            next_st.state = ST_CTR;
          end
        end
      end
      ST_CLR, ST_ENC:
      begin
        if (take && PL_VALID)
        begin
          // Earliest octet lands leftmost; the untouched right side
          // stays zero and becomes the padding.
          idx = 8 * (15 - int'(st.fill));
          next_st.acc[idx +: 8] = PL_DATA; // [RQ12] [RQ10]
          next_st.fill = st.fill + 5'h01;
          next_st.rem  = st.rem - 16'h0001;
        end
        else if (emit)
        begin
          blk.data       = st.acc; // [RQ1] [RQ11]
          blk.kind       = (st.state == ST_CLR) ? KIND_CLEAR : KIND_ENC; // [RQ17]
          blk.last_clear = (st.state == ST_CLR) && (st.rem == 16'h0000); // [RQ20]
          blk.last_enc   = (st.state == ST_ENC) && (st.rem == 16'h0000); // [RQ20]
          push           = 1'b1;
          if (fifo_ready)
          begin
            next_st.acc  = '0;
            next_st.fill = 5'h00;
            if (st.rem == 16'h0000)
            begin
              if ((st.state == ST_CLR) && (st.enc_len != 16'h0000))
              begin
                next_st.rem   = st.enc_len;
                next_st.state = ST_ENC; // [RQ9]
              end
              else
              begin
                next_st.state = ST_CTR; // [RQ19]
              end
            end
          end
        end
      end
      ST_CTR:
      begin
        blk.data = {CTR_FLAGS, nonce_swap(st.nonce), st.ctr}; // [RQ13] [RQ15]
        blk.kind = KIND_CTR;
        push     = 1'b1;
        if (fifo_ready)
        begin
          next_st.ctr = st.ctr + 16'h0001; // [RQ14]
          if (st.ctr == st.nctr)
          begin
            next_st.state = ST_IDLE;
          end
        end
      end
      default:
      begin
        next_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_b0_layout: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ5]
    (push && st.state == ST_B0) |->
      (blk.data[127:120] == B0_FLAGS && blk.data[15:0] == st.enc_len))
    else $error("B_0 flags or length wrong");

  a_nonce_swap: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ6]
    (push && st.state == ST_B0) |->
      (blk.data[119:112] == st.nonce[7:0] && blk.data[23:16] == st.nonce[103:96]))
    else $error("B_0 nonce octet order wrong");

  a_nonce_fields: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ3]
    frame_start |=> (st.nonce[103:88] == $past(FRM_INFO.source_address)
                     && st.nonce[87:72] == $past(FRM_INFO.destination_address)
                     && st.nonce[71:48] == $past(FRM_INFO.temporal_key_id)))
    else $error("nonce fields misplaced");

  a_seq_advance: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ18]
    frame_start |=> (FRAME_SEQUENCE_NUMBER == $past(seq_next)))
    else $error("sequence number not the incremented count");

  a_b1_length: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ7]
    (push && st.state == ST_B1) |->
      (blk.data[127:112] == 16'(st.frm.encryption_offset + 16'h000e)
       && blk.data[7:0] == ZERO_OCTET))
    else $error("B_1 length or trailing octet wrong");

  a_pad_zero: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ10]
    (push && (st.state == ST_CLR || st.state == ST_ENC)) |->
      ((st.acc << (8 * st.fill)) == '0))
    else $error("payload padding not zero");

  a_ctr_start: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ14]
    (st.state == ST_B0) |-> (st.ctr == CTR_RESET))
    else $error("counter not cleared at frame start");

  a_ctr_step: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ13]
    (push && fifo_ready && st.state == ST_CTR && st.ctr != st.nctr) |=>
      (st.state == ST_CTR && st.ctr == 16'($past(st.ctr) + 16'h0001)
       && blk.data[127:120] == CTR_FLAGS))
    else $error("counter block sequence broken");

  a_hold_stall: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ19]
    (push && !fifo_ready) |=> ($stable(st.state) && $stable(st.ctr)))
    else $error("formatter advanced without acceptance");

  a_last_flag: assert property (@(posedge SYS_CLK) disable iff (RST) // [RQ20]
    (push && st.state == ST_ENC && st.rem == 16'h0000) |-> blk.last_enc)
    else $error("last encrypted block not flagged");

endmodule
`default_nettype wire

//--- gbf_core_model.sv
// Behavioural cipher core that takes formatter blocks, promptly or with stalls.
`timescale 1ns/100ps
`default_nettype none
module gbf_core_model
  import gbf_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Block port
  input  wire logic blk_valid,
  output logic      blk_ready,
  // Control and observation
  input  wire logic slow,
  output logic      take
);
  int seed = 32'h4da4;

  initial blk_ready = 1'b1;

  // Ready moves on the falling edge only, so it is settled at every rising edge.
  // In slow mode it is mostly low, which lets the four-word buffer fill up.
  always @(negedge clk)
  begin
    blk_ready <= slow ? (($random(seed) & 3) == 0) : 1'b1;
  end

  assign take = blk_valid & blk_ready & !rst;
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the GCM block formatter.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import gbf_pkg::*;

  logic                SYS_CLK     = 1'b0;
  logic                RST         = 1'b1;
  logic                KEY_INSTALL = 1'b0;
  logic                FRM_VALID   = 1'b0;
  logic                PL_VALID    = 1'b0;
  logic                slow        = 1'b0;
  logic [7:0]          PL_DATA     = 8'h00;
  gbf_frame_t          FRM_INFO    = '0;
  logic                FRM_READY;
  logic                KEY_EXHAUSTED;
  logic                PL_READY;
  logic                BLK_VALID;
  logic                BLK_READY;
  logic                take;
  logic [SEQ_BITS-1:0] FRAME_SEQUENCE_NUMBER;
  gbf_block_t          BLK_OUT;
  int                  failures = 0;
  int                  checks   = 0;
  int                  seed     = 32'h4da4;
  logic [SEQ_BITS-1:0] seq      = '0;
  logic [7:0]          pay[$];
  gbf_block_t          got[$];
  gbf_block_t          exp_q[$];

  gbf_formatter i_gbf_formatter (.SYS_CLK(SYS_CLK), .RST(RST), .KEY_INSTALL(KEY_INSTALL),
    .KEY_EXHAUSTED(KEY_EXHAUSTED), .FRM_VALID(FRM_VALID), .FRM_INFO(FRM_INFO),
    .FRM_READY(FRM_READY), .FRAME_SEQUENCE_NUMBER(FRAME_SEQUENCE_NUMBER),
    .PL_VALID(PL_VALID), .PL_DATA(PL_DATA), .PL_READY(PL_READY), .BLK_VALID(BLK_VALID),
    .BLK_OUT(BLK_OUT), .BLK_READY(BLK_READY));

  gbf_core_model i_gbf_core_model (.clk(SYS_CLK), .rst(RST), .blk_valid(BLK_VALID),
    .blk_ready(BLK_READY), .slow(slow), .take(take));

  always #2.5 SYS_CLK = ~SYS_CLK;

  // Blocks are recorded in the active region, before the buffer registers move.
  always @(posedge SYS_CLK)
  begin
    if (take)
      got.push_back(BLK_OUT);
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input logic [131:0] seen, input logic [131:0] want);
    checks++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Expected blocks
  // ****************************************************************
  function automatic gbf_block_t blk(logic [127:0] d, gbf_kind_t k, logic lc, logic le);
    gbf_block_t b;
    b.data       = d;
    b.kind       = k;
    b.last_clear = lc;
    b.last_enc   = le;
    return b;
  endfunction

  // The nonce is built most-significant first, then laid out octet-reversed.
  function automatic logic [103:0] nrev(gbf_frame_t f, logic [47:0] s);
    logic [103:0] n;
    logic [103:0] r;
    n = {f.source_address, f.destination_address, f.temporal_key_id, s};
    for (int i = 0; i < 13; i++)
      r[103-8*i -: 8] = n[8*i +: 8];
    return r;
  endfunction

  task automatic build(input gbf_frame_t f, input logic [47:0] s);
    logic [103:0] n;
    logic [127:0] d;
    int           off;
    int           enc;
    int           cnt;
    int           st;
    off = (f.encryption_offset < f.payload_length) ? f.encryption_offset : f.payload_length;
    enc = f.payload_length - off;
    n   = nrev(f, s);
    exp_q.push_back(blk({B0_FLAGS, n, enc[15:0]}, KIND_AUTH, 1'b0, 1'b0));
    exp_q.push_back(blk({f.encryption_offset + AAD_BASE, f.mac_header, f.encryption_offset,
      f.security_reserved, ZERO_OCTET}, KIND_AUTH, 1'b0, 1'b0));
    for (int p = 0; p < 2; p++)
    begin
      st  = p ? off : 0;
      cnt = p ? enc : off;
      for (int k = 0; k < cnt; k += 16)
      begin
        d = '0;
        for (int j = 0; j < 16; j++)
          if (k + j < cnt)
            d[127-8*j -: 8] = pay[st+k+j];
        exp_q.push_back(blk(d, p ? KIND_ENC : KIND_CLEAR, !p && k + 16 >= cnt,
          p && k + 16 >= cnt));
      end
    end
    for (int k = 0; k <= (enc + 15) / 16; k++)
      exp_q.push_back(blk({CTR_FLAGS, n, k[15:0]}, KIND_CTR, 1'b0, 1'b0));
  endtask

  // ****************************************************************
  // One frame: description, payload octets, then all blocks compared
  // ****************************************************************
  task automatic run_frame(input int off, input int len);
    gbf_frame_t   f;
    logic [191:0] r;
    int           k;
    int           w;
    int           bad;
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed)};
    f = r[175:0];
    f.encryption_offset = off[15:0];
    f.payload_length    = len[15:0];
    pay.delete();
    for (k = 0; k < len; k++)
    begin
      r = {160'h0, $random(seed)};
      pay.push_back(r[7:0]);
    end
    @(negedge SYS_CLK);
    FRM_INFO  = f;
    FRM_VALID = 1'b1;
    #1;
    for (w = 0; FRM_READY !== 1'b1 && w < 300; w++)
    begin
      @(negedge SYS_CLK);
      #1;
    end
    @(negedge SYS_CLK);
    FRM_VALID = 1'b0;
    seq++;
    build(f, seq);
    check(FRAME_SEQUENCE_NUMBER, seq);
    check(FRM_READY, 1'b0);
    k = 0;
    for (w = 0; k < len && w < 3000; w++)
    begin
      PL_VALID = 1'b1;
      PL_DATA  = pay[k];
      #1;
      if (PL_READY === 1'b1)
        k++;
      @(negedge SYS_CLK);
    end
    PL_DATA = 8'hff;
    bad     = 0;
    for (w = 0; got.size() < exp_q.size() && w < 3000; w++)
    begin
      @(negedge SYS_CLK);
      #1;
      if (PL_READY !== 1'b0)
        bad++;
    end
    PL_VALID = 1'b0;
    check(bad, 0);
    check(got.size(), exp_q.size());
    while (got.size() > 0 && exp_q.size() > 0)
      check(got.pop_front(), exp_q.pop_front());
    got.delete();
    exp_q.delete();
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    int offs[7];
    int lens[7];
    int l;
    offs = '{3, 0, 16, 5, 0, 32, 8};
    lens = '{3, 0, 16, 40, 33, 32, 5};
    repeat (2) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check({FRM_READY, PL_READY, BLK_VALID, KEY_EXHAUSTED}, 4'h8);
    check(FRAME_SEQUENCE_NUMBER, SEQ_RESET);
    RST = 1'b0;
    for (int i = 0; i < 7; i++)
      run_frame(offs[i], lens[i]);
    @(negedge SYS_CLK);
    KEY_INSTALL = 1'b1;
    @(negedge SYS_CLK);
    KEY_INSTALL = 1'b0;
    seq  = SEQ_RESET;
    slow = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      l = $unsigned($random(seed)) % 48;
      run_frame($unsigned($random(seed)) % (l + 1), l);
    end
    check(KEY_EXHAUSTED, 1'b0);
    final_report();
  end

  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
